//--- src/attr_port_pkg.sv
/*
 * attr_port_pkg: port addresses, index layout, reset values and carrier
 * structs for the attribute register port.
 * assumes a 16-bit host I/O address and 8-bit I/O data on one clock.
 */
package attr_port_pkg;

    // host I/O port addresses
    localparam logic [15:0] PORT_INDEX       = 16'h03c0; // index read/write, data write
    localparam logic [15:0] PORT_DATA_RD     = 16'h03c1; // data read
    localparam logic [15:0] PORT_STATUS_MONO = 16'h03ba; // input_status_one, mono emulation
    localparam logic [15:0] PORT_STATUS_CLR  = 16'h03da; // input_status_one, color emulation

    // attribute_index_port layout
    localparam int INDEX_LSB   = 0;
    localparam int INDEX_MSB   = 4;
    localparam int VIDEO_EN_BIT = 5;

    // indexes inside the attribute set
    localparam int          NUM_PALETTE  = 16;
    localparam int          NUM_CONTROL  = 5;
    localparam int          PALETTE_BITS = 6;
    localparam logic [4:0]  IDX_MODE     = 5'h10; // attribute_mode_control
    localparam logic [4:0]  IDX_BORDER   = 5'h11; // border_color
    localparam logic [4:0]  IDX_PLANE    = 5'h12; // plane_output_enable
    localparam logic [4:0]  IDX_PAN      = 5'h13; // horizontal_pan
    localparam logic [4:0]  IDX_COLSEL   = 5'h14; // color_page_select
    localparam logic [4:0]  IDX_LAST     = 5'h14;

    // values after reset
    localparam logic        RST_DATA_PHASE = 1'b0; // toggle in index state
    localparam logic        RST_VIDEO_EN   = 1'b0;
    localparam logic [4:0]  RST_INDEX      = 5'h00;
    localparam logic [5:0]  RST_PALETTE    = 6'h00;
    localparam logic [7:0]  RST_CONTROL    = 8'h00;

    // host I/O request, one cycle per access
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } io_req_t;

    // answer to the host
    typedef struct packed {
        logic        rvalid; // one-cycle pulse, rdata valid
        logic [7:0]  rdata;
    } io_rsp_t;

    // control registers as seen by the video path
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] border;
        logic [7:0] plane;
        logic [7:0] pan;
        logic [7:0] colsel;
    } attr_cfg_t;

endpackage : attr_port_pkg

//--- src/attr_reg_cell.sv
/*
 * attr_reg_cell: one host-writable storage register with load enable.
 * assumes the caller qualifies the load enable; same clock as the host.
 */
`timescale 1ns/10ps
module attr_reg_cell #(
    parameter int               WIDTH     = 8,
    parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // load port
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] d,
    // stored value
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] value;
    } cell_state_t;

    cell_state_t state_reg;
    cell_state_t state_next;

    // hold unless loaded
    always_comb begin
        state_next = state_reg;
        if (load) begin
            state_next.value = d;
        end
    end

    // storage
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg.value <= RST_VALUE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign q = state_reg.value;

endmodule : attr_reg_cell

//--- src/attribute_register_port.sv
/*
 * attribute_register_port: host access port for the attribute
 * controller's indexed registers, with the index/data toggle, the
 * attribute_index_port and the twenty-one attribute registers.
 * the color lookup entries keep six bits each and lock while video
 * runs; the five control registers keep all eight bits and feed the
 * video path directly.
 * reads answer one cycle after their strobe from the state before it,
 * so a read just after a write already returns the written value.
 * assumes host I/O requests arrive on the same clock as one-cycle
 * strobes, never a read and a write together, and that color_emulation
 * comes from the emulation select logic on this clock.
 * assumes the input_status_one data itself comes from another block;
 * this one only watches the access to reset the toggle.
 * a host that has lost track of the toggle must read input_status_one
 * before its next index write, as nothing else resynchronises it.
 */
`timescale 1ns/10ps
module attribute_register_port
    import attr_port_pkg::*;
(
    // clock and reset
    input  wire logic                                  clock,
    input  wire logic                                  resetn,
    // host I/O port
    input  wire io_req_t                               io_req,
    output io_rsp_t                                    io_rsp,
    // emulation select, high for color addresses
    input  wire logic                                  color_emulation,
    // status port access seen, one-cycle pulse
    output logic                                       status_read,
    // toggle state, high when the next shared write is data
    output logic                                       data_phase,
    // video path controls
    output logic                                       video_enable,
    output attr_cfg_t                                  attr_cfg,
    output logic      [NUM_PALETTE-1:0][PALETTE_BITS-1:0] palette
);

    // port state
    typedef struct packed {
        logic       data_phase; // 0: next shared write loads the index
        logic       video_en;
        logic [4:0] index;
        logic [7:0] rdata;
        logic       rvalid;
        logic       status_pulse;
    } port_state_t;

    port_state_t state_reg;
    port_state_t state_next;

    // decoded host cycles
    logic        index_addr;
    logic        data_addr;
    logic        status_mono;
    logic        status_clr;
    logic        status_addr;
    logic        status_hit;
    logic        shared_wr;
    logic        shared_rd;
    logic        data_rd;
    logic        index_wr;
    logic        data_wr;
    logic        palette_open;

    // read sources
    logic        idx_palette;
    logic        idx_control;
    logic [7:0]  palette_word;
    logic [7:0]  control_word;
    logic [7:0]  index_word;

    // register contents
    logic [NUM_PALETTE-1:0][PALETTE_BITS-1:0] pal_q;
    logic [NUM_CONTROL-1:0][7:0]              ctl_q;

    // load enables
    logic [NUM_PALETTE-1:0] pal_load;
    logic [NUM_CONTROL-1:0] ctl_load;

    // address matches, each compared once
    assign index_addr  = (io_req.addr == PORT_INDEX);
    assign data_addr   = (io_req.addr == PORT_DATA_RD);
    assign status_mono = (io_req.addr == PORT_STATUS_MONO);
    assign status_clr  = (io_req.addr == PORT_STATUS_CLR);

    // input_status_one follows the emulation select
    assign status_addr = color_emulation ? status_clr : status_mono;
    assign status_hit  = io_req.rd && status_addr;

    // shared port and data read port
    assign shared_wr = io_req.wr && index_addr;
    assign shared_rd = io_req.rd && index_addr;
    assign data_rd   = io_req.rd && data_addr;

    // the toggle splits shared writes into index and data
    assign index_wr = shared_wr && !state_reg.data_phase;
    assign data_wr  = shared_wr &&  state_reg.data_phase;

    // color lookup entries reachable only with video off
    assign palette_open = !state_reg.video_en;

    // color lookup entries, indexes 00h-0Fh
    for (genvar i = 0; i < NUM_PALETTE; i++) begin : g_palette
        assign pal_load[i] = data_wr && palette_open
                          && (state_reg.index == 5'(i));

        attr_reg_cell #(
            .WIDTH     (PALETTE_BITS),
            .RST_VALUE (RST_PALETTE)
        ) u_palette (
            .clock  (clock),
            .resetn (resetn),
            .load   (pal_load[i]),
            .d      (io_req.wdata[PALETTE_BITS-1:0]),
            .q      (pal_q[i])
        );
    end

    // attribute_mode_control, index 10h
    assign ctl_load[0] = data_wr && (state_reg.index == IDX_MODE);

    attr_reg_cell #(
        .WIDTH     (8),
        .RST_VALUE (RST_CONTROL)
    ) u_attribute_mode_control (
        .clock  (clock),
        .resetn (resetn),
        .load   (ctl_load[0]),
        .d      (io_req.wdata),
        .q      (ctl_q[0])
    );

    // border_color, index 11h
    assign ctl_load[1] = data_wr && (state_reg.index == IDX_BORDER);

    attr_reg_cell #(
        .WIDTH     (8),
        .RST_VALUE (RST_CONTROL)
    ) u_border_color (
        .clock  (clock),
        .resetn (resetn),
        .load   (ctl_load[1]),
        .d      (io_req.wdata),
        .q      (ctl_q[1])
    );

    // plane_output_enable, index 12h
    assign ctl_load[2] = data_wr && (state_reg.index == IDX_PLANE);

    attr_reg_cell #(
        .WIDTH     (8),
        .RST_VALUE (RST_CONTROL)
    ) u_plane_output_enable (
        .clock  (clock),
        .resetn (resetn),
        .load   (ctl_load[2]),
        .d      (io_req.wdata),
        .q      (ctl_q[2])
    );

    // horizontal_pan, index 13h
    assign ctl_load[3] = data_wr && (state_reg.index == IDX_PAN);

    attr_reg_cell #(
        .WIDTH     (8),
        .RST_VALUE (RST_CONTROL)
    ) u_horizontal_pan (
        .clock  (clock),
        .resetn (resetn),
        .load   (ctl_load[3]),
        .d      (io_req.wdata),
        .q      (ctl_q[3])
    );

    // color_page_select, index 14h
    assign ctl_load[4] = data_wr && (state_reg.index == IDX_COLSEL);

    attr_reg_cell #(
        .WIDTH     (8),
        .RST_VALUE (RST_CONTROL)
    ) u_color_page_select (
        .clock  (clock),
        .resetn (resetn),
        .load   (ctl_load[4]),
        .d      (io_req.wdata),
        .q      (ctl_q[4])
    );

    // control register selected by an index in 10h-14h, zero elsewhere
    function automatic logic [7:0] control_pick(
        input logic [4:0]                  idx,
        input logic [NUM_CONTROL-1:0][7:0] regs
    );
        logic [7:0] word;
        word = 8'h00;
        case (idx)
            IDX_MODE:   word = regs[0];
            IDX_BORDER: word = regs[1];
            IDX_PLANE:  word = regs[2];
            IDX_PAN:    word = regs[3];
            IDX_COLSEL: word = regs[4];
            default:    word = 8'h00;
        endcase
        return word;
    endfunction : control_pick

    // read sources for the two read ports; locked entries read as zero
    assign idx_palette  = (state_reg.index < 5'(NUM_PALETTE));
    assign idx_control  = !idx_palette && (state_reg.index <= IDX_LAST);
    assign palette_word = palette_open ? {2'b00, pal_q[state_reg.index[3:0]]}
                                       : 8'h00;
    assign control_word = control_pick(state_reg.index, ctl_q);
    assign index_word   = {2'b00, state_reg.video_en, state_reg.index};

    // next state: toggle, index, read data
    always_comb begin
        state_next              = state_reg;
        state_next.rvalid       = 1'b0;
        state_next.status_pulse = 1'b0;

        // shared port write flips the toggle every time
        if (shared_wr) begin
            state_next.data_phase = !state_reg.data_phase;
        end

        // index phase loads index and enable, reserved bits dropped
        if (index_wr) begin
            state_next.index    = io_req.wdata[INDEX_MSB:INDEX_LSB];
            state_next.video_en = io_req.wdata[VIDEO_EN_BIT];
        end

        // status read forces the index state; data reads leave it
        if (status_hit) begin
            state_next.data_phase   = 1'b0;
            state_next.status_pulse = 1'b1;
        end

        // index register read back
        if (shared_rd) begin
            state_next.rvalid = 1'b1;
            state_next.rdata  = index_word;
        end

        // data port read of the selected register
        if (data_rd) begin
            state_next.rvalid = 1'b1;
            state_next.rdata  = 8'h00;
            if (idx_palette) begin
                state_next.rdata = palette_word;
            end else if (idx_control) begin
                state_next.rdata = control_word;
            end
        end
    end

    // port state registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg.data_phase   <= RST_DATA_PHASE;
            state_reg.video_en     <= RST_VIDEO_EN;
            state_reg.index        <= RST_INDEX;
            state_reg.rdata        <= 8'h00;
            state_reg.rvalid       <= 1'b0;
            state_reg.status_pulse <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // host answer
    assign io_rsp.rvalid = state_reg.rvalid;
    assign io_rsp.rdata  = state_reg.rdata;
    assign status_read   = state_reg.status_pulse;
    assign data_phase    = state_reg.data_phase;

    // video path controls
    assign video_enable   = state_reg.video_en;
    assign attr_cfg.mode   = ctl_q[0];
    assign attr_cfg.border = ctl_q[1];
    assign attr_cfg.plane  = ctl_q[2];
    assign attr_cfg.pan    = ctl_q[3];
    assign attr_cfg.colsel = ctl_q[4];
    assign palette         = pal_q;

endmodule : attribute_register_port

//--- bench/attribute_register_port_sva.sv
/* attribute_register_port_sva: timing checks on the port of the block.
   assumes bind to attribute_register_port, one clock, async reset. */
`timescale 1ns/10ps
module attribute_register_port_sva
    import attr_port_pkg::*;
(
    // clock and reset
    input wire logic                                  clock,
    input wire logic                                  resetn,
    // host side
    input wire io_req_t                               io_req,
    input wire io_rsp_t                               io_rsp,
    input wire logic                                  color_emulation,
    // status and video side
    input wire logic                                  status_read,
    input wire logic                                  data_phase,
    input wire logic                                  video_enable,
    input wire attr_cfg_t                             attr_cfg,
    input wire logic [NUM_PALETTE-1:0][PALETTE_BITS-1:0] palette
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // decoded accesses
    wire shared_wr = io_req.wr && io_req.addr == PORT_INDEX;
    wire idx_rd    = io_req.rd && io_req.addr == PORT_INDEX;
    wire data_rd   = io_req.rd && io_req.addr == PORT_DATA_RD;
    wire sel_addr  = color_emulation ? io_req.addr == PORT_STATUS_CLR
                                     : io_req.addr == PORT_STATUS_MONO;
    wire stat_rd   = io_req.rd && sel_addr;

    toggle_flip_a: assert property (shared_wr |=> data_phase != $past(data_phase))
        else $error("toggle did not flip");
    status_force_a: assert property (stat_rd |=> !data_phase && status_read)
        else $error("status read did not reset toggle");
    status_addr_a: assert property (io_req.rd && !sel_addr |=> !status_read)
        else $error("status seen at wrong address");
    data_rd_keep_a: assert property (data_rd |=> $stable(data_phase))
        else $error("data read moved toggle");
    read_answer_a: assert property (idx_rd || data_rd |=> io_rsp.rvalid)
        else $error("read not answered");
    no_answer_a: assert property (!(idx_rd || data_rd) |=> !io_rsp.rvalid)
        else $error("answer without read");
    index_read_a: assert property (idx_rd |=>
        io_rsp.rdata[7:5] == {2'b00, $past(video_enable)})
        else $error("index read top bits wrong");
    video_load_a: assert property (shared_wr && !data_phase |=>
        video_enable == $past(io_req.wdata[5]) && $stable(attr_cfg))
        else $error("index write mishandled");
    palette_lock_a: assert property (shared_wr && data_phase && video_enable |=>
        $stable(palette))
        else $error("locked palette written");
endmodule : attribute_register_port_sva

bind attribute_register_port attribute_register_port_sva i_sva (.clock(clock), .resetn(resetn),
    .io_req(io_req), .io_rsp(io_rsp), .color_emulation(color_emulation),
    .status_read(status_read), .data_phase(data_phase), .video_enable(video_enable),
    .attr_cfg(attr_cfg), .palette(palette));

//--- bench/host_io_model.sv
/* host_io_model: host processor making single I/O reads and writes.
   assumes the port samples requests on the rising clock edge. */
`timescale 1ns/10ps
module host_io_model
    import attr_port_pkg::*;
(
    // clock
    input wire logic clock,
    // request to the port
    output io_req_t  io_req
);
    initial io_req = '0;
    // one access held over one rising edge, then idle with inverted lines
    task automatic access(input logic rd, input logic [15:0] a, input logic [7:0] d);
        @(negedge clock);
        io_req = '{rd: rd, wr: !rd, addr: a, wdata: d};
        @(negedge clock);
        io_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : access
endmodule : host_io_model

//--- bench/attribute_register_port_bench.sv
/* attribute_register_port_bench: register sequences against the port.
   assumes host_io_model drives requests and the checker is bound. */
`timescale 1ns/10ps
module attribute_register_port_bench;
    import attr_port_pkg::*;
    logic clock = 0, resetn = 0, color_emulation = 0;
    io_req_t io_req;
    io_rsp_t io_rsp;
    logic status_read, data_phase, video_enable;
    attr_cfg_t attr_cfg;
    logic [NUM_PALETTE-1:0][PALETTE_BITS-1:0] palette;
    int fail_count = 0, checked = 0, cycles = 0;

    attribute_register_port i_attribute_register_port (.clock(clock), .resetn(resetn),
        .io_req(io_req), .io_rsp(io_rsp), .color_emulation(color_emulation),
        .status_read(status_read), .data_phase(data_phase), .video_enable(video_enable),
        .attr_cfg(attr_cfg), .palette(palette));
    host_io_model i_host_io_model (.clock(clock), .io_req(io_req));

    always #2.5 clock = ~clock;
    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_host_io_model.access(1'b0, a, d);
        @(negedge clock);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic v, input logic [7:0] e);
        i_host_io_model.access(1'b1, a, 8'h00);
        // the answer stands one cycle only: look before the next rising edge
        check("rvalid", 40'(io_rsp.rvalid), 40'(v));
        if (v)
            check("rdata", 40'(io_rsp.rdata), 40'(e));
    endtask : rd

    // data pattern written to register i
    function automatic logic [7:0] dv(input int i);
        return 8'(i * 37 + 8'hc5);
    endfunction : dv

    initial begin
        repeat (16) @(negedge clock);
        resetn = 1;
        check("phase", 40'(data_phase), 40'h0);
        check("cfg", attr_cfg, 40'h0);
        // write index then data for every index, one past the last too
        for (int i = 0; i < 22; i++) begin
            wr(PORT_INDEX, 8'(i));
            check("phase", 40'(data_phase), 40'h1);
            wr(PORT_INDEX, dv(i));
            check("phase", 40'(data_phase), 40'h0);
        end
        for (int i = 0; i < 16; i++)
            check("palette", 40'(palette[i]), 40'(dv(i) & 8'h3f));
        check("cfg", attr_cfg, {dv(16), dv(17), dv(18), dv(19), dv(20)});
        // read back, then leave data phase through the selected status port
        for (int i = 0; i < 22; i++) begin
            color_emulation = i[0];
            wr(PORT_INDEX, 8'(i));
            rd(PORT_DATA_RD, 1'b1, i < 16 ? dv(i) & 8'h3f : i < 21 ? dv(i) : 8'h00);
            check("phase", 40'(data_phase), 40'h1);
            rd(i[0] ? PORT_STATUS_MONO : PORT_STATUS_CLR, 1'b0, 8'h00);
            check("status", 40'(status_read), 40'h0);
            check("phase", 40'(data_phase), 40'h1);
            rd(i[0] ? PORT_STATUS_CLR : PORT_STATUS_MONO, 1'b0, 8'h00);
            check("status", 40'(status_read), 40'h1);
            check("phase", 40'(data_phase), 40'h0);
        end
        // video on locks the color entries
        wr(PORT_INDEX, 8'he2);
        check("video", 40'(video_enable), 40'h1);
        rd(PORT_INDEX, 1'b1, 8'h22);
        wr(PORT_INDEX, 8'h00);
        check("palette", 40'(palette[2]), 40'(dv(2) & 8'h3f));
        wr(PORT_INDEX, 8'h22);
        rd(PORT_DATA_RD, 1'b1, 8'h00);
        wr(PORT_INDEX, 8'h00);
        // video off opens them again
        wr(PORT_INDEX, 8'h02);
        check("video", 40'(video_enable), 40'h0);
        rd(PORT_INDEX, 1'b1, 8'h02);
        rd(PORT_DATA_RD, 1'b1, dv(2) & 8'h3f);
        wr(PORT_INDEX, 8'hff);
        check("palette", 40'(palette[2]), 40'h3f);
        // unmapped and wrong-direction accesses
        wr(PORT_DATA_RD, 8'h55);
        check("phase", 40'(data_phase), 40'h0);
        rd(16'h03c5, 1'b0, 8'h00);
        give_verdict();
    end
endmodule : attribute_register_port_bench
